// ---- asc_pkg.sv ----
// Constants, types and device command map for the converter serial-port host controller
package asc_pkg;

	// Core clock and serial clock timing
	localparam int unsigned CLK_FREQ_KHZ = 250000;
	localparam int unsigned SCLK_MAX_FREQ_KHZ = 5600;
	localparam int unsigned SCLK_PERIOD_CYC = (CLK_FREQ_KHZ + SCLK_MAX_FREQ_KHZ - 1) / SCLK_MAX_FREQ_KHZ;
	localparam logic [5:0] SCLK_HALF_CYC = 6'((SCLK_PERIOD_CYC + 1) / 2);

	// Command byte layout
	localparam int unsigned CMD_ADDR_MSB = 7;
	localparam int unsigned CMD_ADDR_LSB = 3;
	localparam int unsigned CMD_READ_BIT = 2;
	localparam logic [7:0] CMD_BURST_READ = 8'h04;

	// Device register indices (printed ones first, the rest plain defaults)
	localparam logic [4:0] DEV_CURRENT_WAVE_SAMPLE = 5'h00;
	localparam logic [4:0] DEV_VOLTAGE1_WAVE_SAMPLE = 5'h01;
	localparam logic [4:0] DEV_VOLTAGE2_WAVE_SAMPLE = 5'h02;
	localparam logic [4:0] DEV_FIRST_STATE_WORD = 5'h04;
	localparam logic [4:0] DEV_COUNTER_LATCH_VALUE = 5'h05;
	localparam logic [4:0] DEV_SETUP_REGISTER = 5'h08;
	localparam logic [4:0] DEV_PERIOD_START_LOW = 5'h0a;
	localparam logic [4:0] DEV_PERIOD_START_HIGH = 5'h0b;
	localparam logic [4:0] DEV_ALIGN_LATCH_CONTROL = 5'h0c;

	// Device field positions and command values
	localparam int unsigned SETUP_CLOCK_FORWARD_BIT = 0;
	localparam int unsigned SETUP_RATE_MSB = 5;
	localparam int unsigned SETUP_RATE_LSB = 4;
	localparam logic [7:0] ALIGN_START_PERIOD = 8'h01;
	localparam logic [7:0] ALIGN_LATCH_COUNTER = 8'h02;

	// Host register offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CFG = 8'h08;
	localparam logic [3:0] REG_RBUF_PAGE = 4'h1;

	// Host register fields
	localparam int unsigned CMD_GO_BIT = 31;
	localparam int unsigned CMD_ABORT_BIT = 30;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_READY_SEEN_BIT = 2;
	localparam int unsigned CFG_AUTO_BIT = 0;

	// Sizes and reset values
	localparam int unsigned RBUF_BYTES = 16;
	localparam logic [4:0] RBUF_MAX = 5'd16;
	localparam logic [3:0] CMD_BITS = 4'd8;
	localparam logic [7:0] WRITE_BITS = 8'd16;
	localparam logic [3:0] CS_IDLE = 4'hf;

	typedef struct packed {
		logic [3:0] cs_mask;
		logic [4:0] nbytes;
		logic [7:0] wbyte;
		logic [7:0] cmd;
	} asc_cmd_t;

	localparam asc_cmd_t CMD_RESET = '0;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} asc_apb_req_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_LOW = 5'b00100,
		ST_HIGH = 5'b01000,
		ST_HOLD = 5'b10000
	} asc_state_t;

endpackage : asc_pkg

// ---- asc_sync.sv ----
// Two-flop synchroniser for a pin from outside the clock domain
`timescale 1ns/10ps
module asc_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	logic meta_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : asc_sync

// ---- asc_spi_host.sv ----
// Host-side serial master for the sampling converter, driven from APB registers
//
// Function
// - Command byte: bits 7-3 register index, bit 2 read select, bits 1-0 ignored.
// - Read select 1 means register read, 0 means register write.
// - Host drops chip select, changes MOSI on falling SCLK edges from the first.
// - After the final bit chip select and SCLK return high; MISO floats.
// - Read of index 0 (command 0x04) starts burst with the 24-bit current sample.
// - Host may start burst at a later index and stop early by raising chip select.
// - Write value follows command byte with no idle SCLK; then chip select rises.
// - Writes are 8 bits; 12-bit start value written low byte then high nibble.
// - Software should read back a register after writing it.
// - Setup bits 5-4 select output rate; same value in every device.
// - Host should burst-read the samples after each data-ready pulse.
// - New start value written low byte then high nibble; countdown restarts.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module asc_spi_host (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input asc_pkg::asc_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sclk,
	output logic mosi,
	output logic [3:0] cs_n,
	input wire logic miso,
	input wire logic clock_or_ready_pin
);
	import asc_pkg::*;

	asc_state_t state_q;
	asc_cmd_t cmd_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic addr_hit;
	logic acc;
	logic wr_done;
	logic miso_s;
	logic rdy_s;
	logic rdy_prev_q;
	logic rdy_fall;
	logic auto_q;
	logic done_q;
	logic ready_seen_q;
	logic go_pend_q;
	logic go_req;
	logic abort_req;
	logic status_wr;
	logic done_set;
	logic [5:0] half_q;
	logic [7:0] bits_q;
	logic [3:0] cmdleft_q;
	logic [15:0] tx_q;
	logic [7:0] rx_q;
	logic [2:0] rxbit_q;
	logic [4:0] rxcnt_q;
	logic rd_q;
	logic sclk_q;
	logic mosi_q;
	logic [3:0] cs_n_q;
	logic [7:0] rbuf_q [RBUF_BYTES];
	logic rx_store;
	logic [7:0] rx_byte;

	// Read byte count clamped to the buffer; zero still reads one byte
	function automatic logic [7:0] total_bits(input asc_cmd_t c);
		logic [4:0] n;
		n = c.nbytes;
		if (n == 5'd0) begin
			n = 5'd1;
		end else if (n > RBUF_MAX) begin
			n = RBUF_MAX;
		end
		if (c.cmd[CMD_READ_BIT]) begin
			total_bits = 8'(CMD_BITS) + {n, 3'b000};
		end else begin
			total_bits = WRITE_BITS;
		end
	endfunction : total_bits

	asc_sync #(.RESET_VAL(1'b0)) u_sync_miso (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d(miso),
		.q(miso_s)
	);

	asc_sync #(.RESET_VAL(1'b1)) u_sync_ready (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d(clock_or_ready_pin),
		.q(rdy_s)
	);

	// APB slave: one wait state, writes take effect on the completing edge
	assign acc = apb_req.psel & apb_req.penable;
	assign wr_done = acc & pready_q & apb_req.pwrite & ~pslverr_q;

	always_comb begin
		addr_hit = 1'b0;
		rd_mux = 32'h0000_0000;
		if (apb_req.paddr[7:4] == REG_RBUF_PAGE && apb_req.paddr[1:0] == 2'b00) begin
			addr_hit = 1'b1;
			rd_mux = {rbuf_q[{apb_req.paddr[3:2], 2'd0}], rbuf_q[{apb_req.paddr[3:2], 2'd1}],
				rbuf_q[{apb_req.paddr[3:2], 2'd2}], rbuf_q[{apb_req.paddr[3:2], 2'd3}]};
		end else begin
			case (apb_req.paddr)
				REG_CMD: begin
					addr_hit = 1'b1;
					rd_mux = {7'h00, cmd_q};
				end
				REG_STATUS: begin
					addr_hit = 1'b1;
					rd_mux = {19'h0_0000, rxcnt_q, 4'h0, rdy_s, ready_seen_q, done_q, ~state_q[0]};
				end
				REG_CFG: begin
					addr_hit = 1'b1;
					rd_mux = {31'h0000_0000, auto_q};
				end
				default: begin
					addr_hit = 1'b0;
					rd_mux = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (acc && !pready_q) begin
				pready_q <= 1'b1;
				pslverr_q <= ~addr_hit;
				prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// Command register; fields are frozen while a transfer runs
	assign go_req = wr_done && apb_req.paddr == REG_CMD && apb_req.pwdata[CMD_GO_BIT] && state_q == ST_IDLE;
	assign abort_req = wr_done && apb_req.paddr == REG_CMD && apb_req.pwdata[CMD_ABORT_BIT];
	assign status_wr = wr_done && apb_req.paddr == REG_STATUS;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= CMD_RESET;
			auto_q <= 1'b0;
		end else if (ce) begin
			if (wr_done && apb_req.paddr == REG_CMD && state_q == ST_IDLE && !go_pend_q) begin
				cmd_q <= apb_req.pwdata[24:0];
			end
			if (wr_done && apb_req.paddr == REG_CFG) begin
				auto_q <= apb_req.pwdata[CFG_AUTO_BIT];
			end
		end
	end

	// Data-ready falling edge, read only from the second synchroniser flop
	assign rdy_fall = rdy_prev_q & ~rdy_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdy_prev_q <= 1'b1;
		end else if (ce) begin
			rdy_prev_q <= rdy_s;
		end
	end

	// Pending start: software go, or replay of the stored command on each ready pulse that finds the engine idle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			go_pend_q <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_IDLE && go_pend_q) begin
				go_pend_q <= 1'b0;
			end else if (go_req || (auto_q && rdy_fall && state_q == ST_IDLE)) begin
				go_pend_q <= 1'b1;
			end
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins
	assign done_set = ce && state_q == ST_HOLD && half_q == 6'd0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else if (ce) begin
			if (done_set) begin
				done_q <= 1'b1;
			end else if (status_wr && apb_req.pwdata[STAT_DONE_BIT]) begin
				done_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_seen_q <= 1'b0;
		end else if (ce) begin
			if (rdy_fall) begin
				ready_seen_q <= 1'b1;
			end else if (status_wr && apb_req.pwdata[STAT_READY_SEEN_BIT]) begin
				ready_seen_q <= 1'b0;
			end
		end
	end

	// Serial engine: SCLK idles high, MOSI changes on falling edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			half_q <= 6'd0;
			bits_q <= 8'd0;
			cmdleft_q <= 4'd0;
			tx_q <= 16'h0000;
			rd_q <= 1'b0;
			sclk_q <= 1'b1;
			mosi_q <= 1'b0;
			cs_n_q <= CS_IDLE;
		end else if (ce) begin
			if (abort_req && state_q != ST_IDLE) begin
				state_q <= ST_HOLD;
				cs_n_q <= CS_IDLE;
				sclk_q <= 1'b1;
				mosi_q <= 1'b0;
				half_q <= SCLK_HALF_CYC - 6'd1;
			end else if (state_q != ST_IDLE && half_q != 6'd0) begin
				half_q <= half_q - 6'd1;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (go_pend_q) begin
							cs_n_q <= ~cmd_q.cs_mask;
							tx_q <= {cmd_q.cmd, cmd_q.cmd[CMD_READ_BIT] ? 8'h00 : cmd_q.wbyte};
							rd_q <= cmd_q.cmd[CMD_READ_BIT];
							bits_q <= total_bits(cmd_q);
							cmdleft_q <= CMD_BITS;
							half_q <= SCLK_HALF_CYC - 6'd1;
							state_q <= ST_SETUP;
						end
					end
					ST_SETUP: begin
						sclk_q <= 1'b0;
						mosi_q <= tx_q[15];
						tx_q <= {tx_q[14:0], 1'b0};
						half_q <= SCLK_HALF_CYC - 6'd1;
						state_q <= ST_LOW;
					end
					ST_LOW: begin
						sclk_q <= 1'b1;
						half_q <= SCLK_HALF_CYC - 6'd1;
						state_q <= ST_HIGH;
					end
					ST_HIGH: begin
						bits_q <= bits_q - 8'd1;
						if (cmdleft_q != 4'd0) begin
							cmdleft_q <= cmdleft_q - 4'd1;
						end
						half_q <= SCLK_HALF_CYC - 6'd1;
						if (bits_q == 8'd1) begin
							cs_n_q <= CS_IDLE;
							mosi_q <= 1'b0;
							state_q <= ST_HOLD;
						end else begin
							sclk_q <= 1'b0;
							mosi_q <= tx_q[15];
							tx_q <= {tx_q[14:0], 1'b0};
							state_q <= ST_LOW;
						end
					end
					ST_HOLD: begin
						state_q <= ST_IDLE;
					end
					default: begin
						state_q <= ST_IDLE;
						cs_n_q <= CS_IDLE;
						sclk_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// Read data is taken late in the high phase, well after the two-flop delay
	assign rx_store = ce && state_q == ST_HIGH && half_q == 6'd0 && rd_q && cmdleft_q == 4'd0 && !abort_req;
	assign rx_byte = {rx_q[6:0], miso_s};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= 8'h00;
			rxbit_q <= 3'd0;
			rxcnt_q <= 5'd0;
		end else if (ce) begin
			if (state_q == ST_IDLE && go_pend_q) begin
				rxbit_q <= 3'd0;
				rxcnt_q <= 5'd0;
			end else if (rx_store) begin
				rx_q <= rx_byte;
				rxbit_q <= rxbit_q + 3'd1;
				if (rxbit_q == 3'd7) begin
					rxcnt_q <= rxcnt_q + 5'd1;
				end
			end
		end
	end

	// Buffer has no reset; a byte count in status says what is valid
	always_ff @(posedge clk) begin
		if (rx_store && rxbit_q == 3'd7) begin
			rbuf_q[rxcnt_q[3:0]] <= rx_byte;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign sclk = sclk_q;
	assign mosi = mosi_q;
	assign cs_n = cs_n_q;
endmodule : asc_spi_host

// ---- asc_monitor.sv ----
// Checker for the host controller's serial pins and APB answers
`timescale 1ns/10ps
module asc_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input asc_pkg::asc_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic [3:0] cs_n,
	input wire logic miso,
	input wire logic clock_or_ready_pin
);
	import asc_pkg::*;
	logic sclk_q;
	logic [5:0] half_q;
	logic [7:0] bits_q;
	logic [7:0] cmd_q;
	logic cut_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Counted from the pins alone, so a slip in the design's own counters shows
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b1;
			half_q <= '0;
			bits_q <= '0;
			cmd_q <= '0;
			cut_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			half_q <= (sclk != sclk_q) ? 6'd0 : half_q + 6'd1;
			bits_q <= (&cs_n) ? 8'd0 : bits_q + 8'(sclk && !sclk_q);
			if (sclk && !sclk_q && bits_q < 8'd8) cmd_q <= {cmd_q[6:0], mosi};
			// An abort may cut a frame anywhere, so the frame-shape checks stand aside for that edge
			cut_q <= !(&cs_n) && apb_req.psel && apb_req.penable && pready && apb_req.pwrite &&
				apb_req.paddr == REG_CMD && apb_req.pwdata[CMD_ABORT_BIT];
		end
	end
	property p_wait; apb_req.psel && apb_req.penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("no answer after one wait state");
	property p_pulse; pready |-> apb_req.psel && apb_req.penable ##1 !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready outside one access cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_mosi; !(&cs_n) && !(&$past(cs_n)) && $changed(mosi) |-> $fell(sclk); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved off a falling sclk");
	property p_idle; !sclk |-> !(&cs_n); endproperty
	a_idle: assert property (p_idle) else $error("sclk low while deselected");
	property p_cs; !(&cs_n) && !(&$past(cs_n)) |-> $stable(cs_n); endproperty
	a_cs: assert property (p_cs) else $error("chip selects moved in a transfer");
	property p_half; $rose(sclk) && !cut_q |-> half_q == SCLK_HALF_CYC - 6'd1; endproperty
	a_half: assert property (p_half) else $error("sclk low phase wrong length");
	property p_end; $rose(&cs_n) && !cut_q |-> sclk && half_q == SCLK_HALF_CYC - 6'd1; endproperty
	a_end: assert property (p_end) else $error("bad end of transfer");
	property p_wlen; $rose(&cs_n) && !cut_q && !cmd_q[CMD_READ_BIT] |-> bits_q == 8'd16; endproperty
	a_wlen: assert property (p_wlen) else $error("write not sixteen bits");
	property p_rlen; $rose(&cs_n) && !cut_q && cmd_q[CMD_READ_BIT] |->
		bits_q[2:0] == 3'd0 && bits_q > 8'd8; endproperty
	a_rlen: assert property (p_rlen) else $error("read not whole bytes");
	property p_cut; cut_q |-> (&cs_n) && sclk; endproperty
	a_cut: assert property (p_cut) else $error("abort did not release the link");
	c_cut: cover property (cut_q);
	c_write: cover property ($rose(&cs_n) && bits_q == 8'd16);
	c_burst: cover property ($rose(&cs_n) && bits_q == 8'd136);
	c_err: cover property (pslverr);
endmodule : asc_monitor
bind asc_spi_host asc_monitor mon (.clk(clk), .resetn(resetn), .ce(ce), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso),
	.clock_or_ready_pin(clock_or_ready_pin));

// ---- asc_dev_model.sv ----
// Behavioural converter: serial port, registers and period counter
`timescale 1ns/10ps
module asc_dev_model (
	input wire logic clk,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	output logic miso,
	output logic ready_n
);
	import asc_pkg::*;
	logic [23:0] wave [0:2];
	logic [7:0] setup, pst_lo, cmd, wv;
	logic [3:0] pst_hi;
	logic [11:0] cnt, latch;
	logic [6:0] pulse;
	logic [31:0] sh;
	logic [4:0] idx;
	logic core_q, wr_tgl, seen;
	int nbit, left;
	initial begin
		wave[0] = 24'ha5c31e;
		wave[1] = 24'h5a3ce1;
		wave[2] = 24'h0f1e2d;
		{setup, pst_lo, cmd, wv, pst_hi, cnt, latch, pulse, idx, core_q, wr_tgl, seen, miso} = '0;
	end
	function automatic int width_of(input logic [4:0] i);
		return (i <= DEV_VOLTAGE2_WAVE_SAMPLE) ? 24 : (i == DEV_COUNTER_LATCH_VALUE) ? 16 : 8;
	endfunction : width_of
	function automatic logic [31:0] value_of(input logic [4:0] i);
		case (i)
			DEV_CURRENT_WAVE_SAMPLE, DEV_VOLTAGE1_WAVE_SAMPLE, DEV_VOLTAGE2_WAVE_SAMPLE: return {wave[i[1:0]], 8'h00};
			DEV_COUNTER_LATCH_VALUE: return {4'h0, latch, 16'h0};
			DEV_SETUP_REGISTER: return {setup, 24'h0};
			DEV_PERIOD_START_LOW: return {pst_lo, 24'h0};
			DEV_PERIOD_START_HIGH: return {4'h0, pst_hi, 24'h0};
			default: return '0;
		endcase
	endfunction : value_of
	function automatic logic [11:0] reload();
		return 12'((32'd512 << setup[5:4]) - 32'd1);
	endfunction : reload
	// A write commits only on its sixteenth bit, so a cut transfer changes nothing
	always @(posedge sclk) begin
		if (!cs_n) begin
			if (nbit < 8) cmd = {cmd[6:0], mosi};
			else if (nbit < 16) wv = {wv[6:0], mosi};
			nbit++;
			if (nbit == 8) idx = cmd[7:3];
			if (nbit == 16 && !cmd[2]) wr_tgl = ~wr_tgl;
		end
	end
	always @(negedge cs_n) begin
		nbit = 0;
		left = 0;
	end
	always @(posedge cs_n) miso <= ~miso;
	always @(negedge sclk) begin
		if (!cs_n && cmd[2] && nbit >= 8) begin
			if (left == 0) begin
				sh = value_of(idx);
				left = width_of(idx);
				idx++;
			end
			miso <= sh[31];
			sh = sh << 1;
			left--;
		end
	end
	assign ready_n = setup[0] ? core_q : (pulse == 7'd0);
	always @(posedge clk) begin
		core_q <= ~core_q;
		if (wr_tgl != seen) begin
			seen <= wr_tgl;
			case (idx)
				DEV_SETUP_REGISTER: setup <= wv;
				DEV_PERIOD_START_LOW: pst_lo <= wv;
				DEV_PERIOD_START_HIGH: begin
					pst_hi <= wv[3:0];
					cnt <= {wv[3:0], pst_lo};
				end
				DEV_ALIGN_LATCH_CONTROL: begin
					if (wv[0]) cnt <= reload();
					if (wv[0]) pulse <= 7'd64;
					if (wv[1]) latch <= cnt;
				end
				default: ;
			endcase
		end else if (core_q) begin
			if (pulse != 7'd0) pulse <= pulse - 7'd1;
			if (cnt == 12'd0) pulse <= 7'd64;
			cnt <= (cnt == 12'd0) ? reload() : cnt - 12'd1;
		end
	end
endmodule : asc_dev_model

// ---- testbench.sv ----
// Bench: APB master driving the host controller against the converter model
`timescale 1ns/10ps
module testbench;
	import asc_pkg::*;
	logic clk, resetn, pready, pslverr, sclk, mosi, miso, ready_n, err, ce_in;
	asc_apb_req_t req;
	logic [31:0] prdata, rd, st, pins;
	logic [3:0] cs_n;
	int bad_count, n_compared, freeze;
	asc_spi_host dut (.clk(clk), .resetn(resetn), .ce(ce_in), .apb_req(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso), .clock_or_ready_pin(ready_n));
	asc_dev_model dev (.clk(clk), .sclk(sclk), .mosi(mosi), .cs_n(cs_n[0]), .miso(miso), .ready_n(ready_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic timeout(input string what);
		bad_count++;
		$display("[FAIL] %0t no answer: %s", $time, what);
		finish_test();
	endtask : timeout
	// Released after the answer edge, then one idle edge so no signal is driven twice in a step
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= addr;
		req.pwdata <= wdata;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) timeout("apb");
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic xfer(input logic [3:0] mask, input logic [4:0] nb, input logic [7:0] wb, input logic [7:0] cmd);
		int n;
		apb(1'b1, REG_CMD, {1'b1, 6'h00, mask, nb, wb, cmd});
		for (n = 0; cs_n === CS_IDLE && n < 20; n++) @(posedge clk);
		check({28'h0, cs_n}, {28'h0, ~mask}, "chip selects");
		// Clock enable held low in the lead-in half period: no pin may move
		if (freeze > 0) begin
			ce_in <= 1'b0;
			@(posedge clk);
			pins = {29'h0, sclk, mosi, cs_n[0]};
			repeat (freeze) begin
				@(posedge clk);
				check({29'h0, sclk, mosi, cs_n[0]}, pins, "frozen pins");
			end
			ce_in <= 1'b1;
		end
		poll(STAT_DONE_BIT, 1'b1);
		st = rd;
		if (cmd[CMD_READ_BIT]) check({27'h0, st[12:8]}, {27'h0, nb}, "bytes received");
		apb(1'b1, REG_STATUS, 32'h6);
	endtask : xfer
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[b] !== v && n < 3000);
		if (rd[b] !== v) timeout("status");
	endtask : poll
	initial begin
		req = '0;
		ce_in = 1'b1;
		freeze = 0;
		resetn = 1'b0;
		bad_count = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		check(32'({sclk, mosi, cs_n}), 32'({1'b1, 1'b0, CS_IDLE}), "idle pins");
		@(posedge clk);
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped");
		xfer(4'h1, 5'd1, 8'h00, {DEV_SETUP_REGISTER, 3'b100});
		apb(1'b0, 8'h10, 32'h0);
		check({24'h0, rd[31:24]}, 32'h0, "setup reset");
		freeze = 30;
		xfer(4'h1, 5'd1, 8'h31, {DEV_SETUP_REGISTER, 3'b000});
		freeze = 0;
		xfer(4'h1, 5'd1, 8'h00, {DEV_SETUP_REGISTER, 3'b111});
		apb(1'b0, 8'h10, 32'h0);
		check({24'h0, rd[31:24]}, 32'h31, "setup readback");
		check({31'h0, st[STAT_READY_SEEN_BIT]}, 32'h1, "forwarded clock");
		xfer(4'h1, 5'd1, 8'h00, {DEV_SETUP_REGISTER, 3'b000});
		xfer(4'h3, 5'd1, ALIGN_START_PERIOD, {DEV_ALIGN_LATCH_CONTROL, 3'b000});
		check({31'h0, st[3]}, 32'h0, "ready after align");
		xfer(4'h1, 5'd16, 8'h00, CMD_BURST_READ);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'ha5c31e5a, "burst word 0");
		apb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h3ce10f1e, "burst word 1");
		xfer(4'h1, 5'd3, 8'h00, {DEV_VOLTAGE1_WAVE_SAMPLE, 3'b100});
		apb(1'b0, 8'h10, 32'h0);
		check({8'h0, rd[31:8]}, 32'h5a3ce1, "late burst start");
		xfer(4'h1, 5'd1, 8'h34, {DEV_PERIOD_START_LOW, 3'b000});
		xfer(4'h1, 5'd1, 8'h0f, {DEV_PERIOD_START_HIGH, 3'b000});
		xfer(4'h1, 5'd1, ALIGN_LATCH_COUNTER, {DEV_ALIGN_LATCH_CONTROL, 3'b000});
		xfer(4'h1, 5'd2, 8'h00, {DEV_COUNTER_LATCH_VALUE, 3'b100});
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, rd[31:16] > 16'h01ff && rd[31:16] <= 16'h0f34}, 32'h1, "latched count");
		apb(1'b1, REG_CMD, {1'b1, 6'h00, 4'h1, 5'd1, 8'h3f, DEV_SETUP_REGISTER, 3'b000});
		repeat (300) @(posedge clk);
		apb(1'b1, REG_CMD, 32'h4000_0000);
		check({28'h0, cs_n}, {28'h0, CS_IDLE}, "abort releases");
		poll(STAT_BUSY_BIT, 1'b0);
		apb(1'b1, REG_STATUS, 32'h6);
		xfer(4'h1, 5'd1, 8'h00, {DEV_SETUP_REGISTER, 3'b100});
		apb(1'b0, 8'h10, 32'h0);
		check({24'h0, rd[31:24]}, 32'h0, "setup after abort");
		apb(1'b1, REG_CMD, {7'h00, 4'h1, 5'd1, 8'h00, CMD_BURST_READ});
		apb(1'b1, REG_CFG, 32'h1);
		apb(1'b0, REG_CFG, 32'h0);
		check(rd, 32'h1, "auto readback");
		poll(STAT_DONE_BIT, 1'b1);
		apb(1'b1, REG_CFG, 32'h0);
		poll(STAT_BUSY_BIT, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		check({24'h0, rd[31:24]}, 32'ha5, "auto burst");
		finish_test();
	end
endmodule : testbench
